// file: pdm_pkg.sv
// constants shared by the port d alternate function mux and its pin cell
// assumes one system clock domain and an asynchronous active-high reset
package pdm_pkg;

    localparam int unsigned NUM_PINS = 8;

    // pin positions of the alternate functions
    localparam int unsigned PIN_CMP0 = 7;
    localparam int unsigned PIN_IRQ0 = 6;
    localparam int unsigned PIN_CMP2 = 5;
    localparam int unsigned PIN_RX   = 4;
    localparam int unsigned PIN_TX   = 3;
    localparam int unsigned PIN_MISO = 2;
    localparam int unsigned PIN_DCLK = 1;
    localparam int unsigned PIN_SCLK = 0;

    // values after reset
    localparam logic RST_PULLUP = 1'b0;
    localparam logic RST_OE_N   = 1'b1;
    localparam logic RST_OUT    = 1'b0;
    localparam logic RST_DIN    = 1'b0;
    localparam logic RST_SS_N   = 1'b1;
    localparam logic RST_SPI_IN = 1'b0;

    // cycles from a sampled input to the registered output it steers
    localparam int unsigned PIN_LATENCY = 1;
    localparam int unsigned SPI_IN_LATENCY = 2;

endpackage : pdm_pkg

// file: pdm_pin_cell.sv
// one pin of the port: merges port bits with alternate function overrides
// assumes override terms are settled before each clock edge
`timescale 1ns/1ns
module pdm_pin_cell #(
    parameter bit KEEP_IN_RESET = 1'b0
) (
    input  wire logic clk_sys_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    input  wire logic port_out_i,
    input  wire logic port_dir_i,
    input  wire logic pin_i,
    input  wire logic global_pullup_disable_i,
    input  wire logic pullup_override_enable_i,
    input  wire logic pullup_override_value_i,
    input  wire logic direction_override_enable_i,
    input  wire logic direction_override_value_i,
    input  wire logic output_value_override_enable_i,
    input  wire logic output_value_override_value_i,
    input  wire logic input_enable_override_enable_i,
    input  wire logic input_enable_override_value_i,
    output logic      pullup_o,
    output logic      oe_n_o,
    output logic      out_o,
    output logic      din_o
);
    import pdm_pkg::*;

    logic pullup_reg, pullup_next;
    logic oe_n_reg,   oe_n_next;
    logic out_reg,    out_next;
    logic din_reg,    din_next;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        pullup_next = pullup_override_enable_i ? pullup_override_value_i
                    : (port_out_i & ~port_dir_i & ~global_pullup_disable_i);
        oe_n_next   = direction_override_enable_i ? ~direction_override_value_i
                    : ~port_dir_i;
        out_next    = output_value_override_enable_i ? output_value_override_value_i
                    : port_out_i;
        din_next    = pin_i & (input_enable_override_enable_i
                    ? input_enable_override_value_i : 1'b1);
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pullup_reg <= RST_PULLUP;
            din_reg    <= RST_DIN;
        end else if (ce_i) begin
            pullup_reg <= pullup_next;
            din_reg    <= din_next;
        end
    end

    // a pin that must keep toggling in reset has unreset drive flops
    generate
        if (KEEP_IN_RESET) begin : g_live
            always_ff @(posedge clk_sys_i) begin
                if (ce_i) begin
                    oe_n_reg <= oe_n_next;
                    out_reg  <= out_next;
                end
            end
        end else begin : g_reset
            always_ff @(posedge clk_sys_i or posedge rst_i) begin
                if (rst_i) begin
                    oe_n_reg <= RST_OE_N;
                    out_reg  <= RST_OUT;
                end else if (ce_i) begin
                    oe_n_reg <= oe_n_next;
                    out_reg  <= out_next;
                end
            end
        end
    endgenerate

    assign pullup_o = pullup_reg;
    assign oe_n_o   = oe_n_reg;
    assign out_o    = out_reg;
    assign din_o    = din_reg;

endmodule : pdm_pin_cell

// file: pdm_port_d_mux.sv
// alternate function override logic for the eight pins of port d
// assumes port bits and peripheral enables are synchronous to clk_sys_i;
// the pad ring resolves pad_out_o / pad_oe_n_o / pad_pullup_o to the wire
//
// Contract
// - pin 6 input feeds external interrupt zero
// - receiver enable forces pin 4 to input
// - receiver-forced pin 4 pulls up from port bit
// - pin 4 input feeds timer 1 capture
// - spi clock pin: slave input, master follows direction
// - spi-forced inputs keep pull-up from port bit
// - transmitter enable forces pin 3 to output
// - slave select pin 3 input, active low
// - mosi pin 3: slave input, master follows direction
// - miso pin 2: master input, slave follows direction
// - clock fuse puts divided clock on pin 1
// - serial clock pin 0 only in synchronous mode
// - slave select pin 0 input, active low
// - power stage output forces pin 0 output
// - pin 4 direction override from receiver or spi slave, value zero
`timescale 1ns/1ns
module pdm_port_d_mux #(
    parameter int unsigned WIDTH = pdm_pkg::NUM_PINS
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    input  wire logic [WIDTH-1:0] port_out_i,
    input  wire logic [WIDTH-1:0] port_dir_i,
    input  wire logic [WIDTH-1:0] pin_i,
    input  wire logic [WIDTH-1:0] analog_digital_disable_i,
    input  wire logic             global_pullup_disable_i,
    input  wire logic             receiver_enable_i,
    input  wire logic             transmitter_enable_i,
    input  wire logic             tx_data_i,
    input  wire logic             serial_sync_mode_select_i,
    input  wire logic             serial_transfer_clock_out_i,
    input  wire logic             spi_enable_bit_i,
    input  wire logic             spi_master_select_i,
    input  wire logic             spi_pin_set_select_i,
    input  wire logic             spi_sck_out_i,
    input  wire logic             spi_mosi_out_i,
    input  wire logic             spi_miso_out_i,
    input  wire logic             timer0_compare_out_enable_i,
    input  wire logic             timer0_compare_a_out_i,
    input  wire logic             timer1_compare_out_enable_i,
    input  wire logic             timer1_compare_a_out_i,
    input  wire logic             stage0_output0_enable_i,
    input  wire logic             stage0_output0_i,
    input  wire logic             clock_output_fuse_i,
    input  wire logic             divided_clock_i,
    input  wire logic             ext_irq_zero_input_enable_i,
    output logic      [WIDTH-1:0] pad_out_o,
    output logic      [WIDTH-1:0] pad_oe_n_o,
    output logic      [WIDTH-1:0] pad_pullup_o,
    output logic      [WIDTH-1:0] pin_value_o,
    output logic                  ext_irq_zero_o,
    output logic                  timer1_capture_in_o,
    output logic                  stage2_digital_in_o,
    output logic                  stage0_digital_in_o,
    output logic                  serial_transfer_clock_in_o,
    output logic                  spi_sck_in_o,
    output logic                  spi_mosi_in_o,
    output logic                  spi_miso_in_o,
    output logic                  spi_slave_select_n_o
);
    import pdm_pkg::*;

    logic             spi_slave;
    logic             spi_master;
    logic [WIDTH-1:0] pu_en, pu_val, dd_en, dd_val, pv_en, pv_val, ie_en, ie_val;
    logic [WIDTH-1:0] din;

    ////////////////////////////////////////////////////////////////////////////
    // override terms
    assign spi_slave  = spi_enable_bit_i & ~spi_master_select_i & spi_pin_set_select_i;
    assign spi_master = spi_enable_bit_i & spi_master_select_i & spi_pin_set_select_i;

    always_comb begin
        pu_en  = '0;
        pu_val = '0;
        dd_en  = '0;
        dd_val = '0;
        pv_en  = '0;
        pv_val = '0;
        ie_en  = analog_digital_disable_i;
        ie_val = '0;
        // comparator pins only get their digital input cut; the pull-up
        // and direction stay with software
        ie_en[PIN_IRQ0]  = analog_digital_disable_i[PIN_IRQ0] | ext_irq_zero_input_enable_i;
        ie_val[PIN_IRQ0] = ext_irq_zero_input_enable_i;
        // pin 4: receive data, capture input, alternate spi clock
        pu_en[PIN_RX]  = receiver_enable_i | spi_slave;
        pu_val[PIN_RX] = port_out_i[PIN_RX] & ~global_pullup_disable_i;
        dd_en[PIN_RX]  = receiver_enable_i | spi_slave;
        dd_val[PIN_RX] = 1'b0;
        pv_en[PIN_RX]  = spi_master;
        pv_val[PIN_RX] = spi_sck_out_i;
        // pin 3: transmit data, timer 0 compare, slave select, mosi
        pu_en[PIN_TX]  = transmitter_enable_i | spi_slave;
        pu_val[PIN_TX] = ~transmitter_enable_i & port_out_i[PIN_TX]
                       & ~global_pullup_disable_i;
        dd_en[PIN_TX]  = transmitter_enable_i | spi_slave;
        dd_val[PIN_TX] = transmitter_enable_i;
        // compare output reaches the pad only if software set the direction
        pv_en[PIN_TX]  = transmitter_enable_i | timer0_compare_out_enable_i
                       | spi_master;
        if (transmitter_enable_i) begin
            pv_val[PIN_TX] = tx_data_i;
        end else if (timer0_compare_out_enable_i) begin
            pv_val[PIN_TX] = timer0_compare_a_out_i;
        end else begin
            pv_val[PIN_TX] = spi_mosi_out_i;
        end
        // pin 2: timer 1 compare, miso
        pu_en[PIN_MISO]  = spi_master;
        pu_val[PIN_MISO] = port_out_i[PIN_MISO] & ~global_pullup_disable_i;
        dd_en[PIN_MISO]  = spi_master;
        dd_val[PIN_MISO] = 1'b0;
        pv_en[PIN_MISO]  = timer1_compare_out_enable_i | spi_slave;
        pv_val[PIN_MISO] = timer1_compare_out_enable_i ? timer1_compare_a_out_i
                         : spi_miso_out_i;
        // pin 1: divided clock wins over port bits, also in reset
        dd_en[PIN_DCLK]  = clock_output_fuse_i;
        dd_val[PIN_DCLK] = 1'b1;
        pv_en[PIN_DCLK]  = clock_output_fuse_i;
        pv_val[PIN_DCLK] = divided_clock_i;
        // pin 0: power stage output, serial clock, alternate slave select
        pu_en[PIN_SCLK]  = spi_slave;
        pu_val[PIN_SCLK] = port_out_i[PIN_SCLK] & ~global_pullup_disable_i;
        dd_en[PIN_SCLK]  = stage0_output0_enable_i | spi_slave;
        dd_val[PIN_SCLK] = stage0_output0_enable_i;
        pv_en[PIN_SCLK]  = stage0_output0_enable_i | serial_sync_mode_select_i;
        pv_val[PIN_SCLK] = stage0_output0_enable_i ? stage0_output0_i
                         : serial_transfer_clock_out_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one cell per pin
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_pin
            pdm_pin_cell #(
                .KEEP_IN_RESET (g == PIN_DCLK)
            ) u_cell (
                .clk_sys_i                      (clk_sys_i),
                .rst_i                          (rst_i),
                .ce_i                           (ce_i),
                .port_out_i                     (port_out_i[g]),
                .port_dir_i                     (port_dir_i[g]),
                .pin_i                          (pin_i[g]),
                .global_pullup_disable_i        (global_pullup_disable_i),
                .pullup_override_enable_i       (pu_en[g]),
                .pullup_override_value_i        (pu_val[g]),
                .direction_override_enable_i    (dd_en[g]),
                .direction_override_value_i     (dd_val[g]),
                .output_value_override_enable_i (pv_en[g]),
                .output_value_override_value_i  (pv_val[g]),
                .input_enable_override_enable_i (ie_en[g]),
                .input_enable_override_value_i  (ie_val[g]),
                .pullup_o                       (pad_pullup_o[g]),
                .oe_n_o                         (pad_oe_n_o[g]),
                .out_o                          (pad_out_o[g]),
                .din_o                          (din[g])
            );
        end
    endgenerate

    assign pin_value_o                = din;
    assign ext_irq_zero_o             = din[PIN_IRQ0];
    assign timer1_capture_in_o        = din[PIN_RX];
    assign stage2_digital_in_o        = din[PIN_MISO];
    assign stage0_digital_in_o        = din[PIN_DCLK];
    assign serial_transfer_clock_in_o = din[PIN_SCLK];

    ////////////////////////////////////////////////////////////////////////////
    // spi inputs from the alternate pin set; one extra stage so the gating
    // by the pin set select never glitches the spi core
    logic sck_in_reg,  sck_in_next;
    logic mosi_in_reg, mosi_in_next;
    logic miso_in_reg, miso_in_next;
    logic ss_n_reg,    ss_n_next;

    always_comb begin
        sck_in_next  = din[PIN_RX] & spi_pin_set_select_i;
        mosi_in_next = din[PIN_TX] & spi_pin_set_select_i;
        miso_in_next = din[PIN_MISO] & spi_pin_set_select_i;
        // either slave select pin low activates the slave
        ss_n_next    = ~(spi_pin_set_select_i
                     & (~din[PIN_TX] | ~din[PIN_SCLK]));
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            sck_in_reg  <= RST_SPI_IN;
            mosi_in_reg <= RST_SPI_IN;
            miso_in_reg <= RST_SPI_IN;
            ss_n_reg    <= RST_SS_N;
        end else if (ce_i) begin
            sck_in_reg  <= sck_in_next;
            mosi_in_reg <= mosi_in_next;
            miso_in_reg <= miso_in_next;
            ss_n_reg    <= ss_n_next;
        end
    end

    assign spi_sck_in_o         = sck_in_reg;
    assign spi_mosi_in_o        = mosi_in_reg;
    assign spi_miso_in_o        = miso_in_reg;
    assign spi_slave_select_n_o = ss_n_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_rx_input;
        @(posedge clk_sys_i) disable iff (rst_i)
        ce_i && receiver_enable_i |=> pad_oe_n_o[PIN_RX];
    endproperty
    a_rx_input: assert property (p_rx_input) else $error("rx pin not input");

    property p_rx_pullup;
        @(posedge clk_sys_i) disable iff (rst_i)
        ce_i && receiver_enable_i && port_out_i[PIN_RX] && !global_pullup_disable_i
        |=> pad_pullup_o[PIN_RX];
    endproperty
    a_rx_pullup: assert property (p_rx_pullup) else $error("rx pull-up off");

    property p_irq_pin;
        @(posedge clk_sys_i) disable iff (rst_i)
        ce_i && (ext_irq_zero_input_enable_i || !analog_digital_disable_i[PIN_IRQ0])
        |=> ext_irq_zero_o == $past(pin_i[PIN_IRQ0]);
    endproperty
    a_irq_pin: assert property (p_irq_pin) else $error("irq input wrong");

    property p_capture;
        @(posedge clk_sys_i) disable iff (rst_i)
        ce_i && !analog_digital_disable_i[PIN_RX]
        |=> timer1_capture_in_o == $past(pin_i[PIN_RX]);
    endproperty
    a_capture: assert property (p_capture) else $error("capture input wrong");

    property p_sck_master;
        @(posedge clk_sys_i) disable iff (rst_i)
        ce_i && spi_master && !receiver_enable_i
        |=> pad_oe_n_o[PIN_RX] == !$past(port_dir_i[PIN_RX]);
    endproperty
    a_sck_master: assert property (p_sck_master) else $error("sck dir wrong");

    property p_tx_drive;
        @(posedge clk_sys_i) disable iff (rst_i)
        ce_i && transmitter_enable_i
        |=> !pad_oe_n_o[PIN_TX] && pad_out_o[PIN_TX] == $past(tx_data_i);
    endproperty
    a_tx_drive: assert property (p_tx_drive) else $error("tx not driven");

    property p_ss_slave;
        @(posedge clk_sys_i) disable iff (rst_i)
        ce_i && spi_slave && !transmitter_enable_i |=> pad_oe_n_o[PIN_TX];
    endproperty
    a_ss_slave: assert property (p_ss_slave) else $error("ss not input");

    property p_miso_master;
        @(posedge clk_sys_i) disable iff (rst_i)
        ce_i && spi_master |=> pad_oe_n_o[PIN_MISO];
    endproperty
    a_miso_master: assert property (p_miso_master) else $error("miso not input");

    property p_clock_out;
        @(posedge clk_sys_i) disable iff (rst_i)
        ce_i && clock_output_fuse_i
        |=> !pad_oe_n_o[PIN_DCLK] && pad_out_o[PIN_DCLK] == $past(divided_clock_i);
    endproperty
    a_clock_out: assert property (p_clock_out) else $error("clock not out");

    property p_psc_out;
        @(posedge clk_sys_i) disable iff (rst_i)
        ce_i && stage0_output0_enable_i
        |=> !pad_oe_n_o[PIN_SCLK] && pad_out_o[PIN_SCLK] == $past(stage0_output0_i);
    endproperty
    a_psc_out: assert property (p_psc_out) else $error("stage out wrong");

    property p_freeze;
        @(posedge clk_sys_i) disable iff (rst_i)
        !ce_i |=> $stable(pad_oe_n_o) && $stable(pad_pullup_o);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved");

    c_rx:    cover property (@(posedge clk_sys_i) disable iff (rst_i)
                 ce_i && receiver_enable_i ##1 pad_pullup_o[PIN_RX]);
    c_tx:    cover property (@(posedge clk_sys_i) disable iff (rst_i)
                 ce_i && transmitter_enable_i ##1 !pad_oe_n_o[PIN_TX]);
    c_slave: cover property (@(posedge clk_sys_i) disable iff (rst_i)
                 ce_i && spi_slave ##2 !spi_slave_select_n_o);
    c_dclk:  cover property (@(posedge clk_sys_i) disable iff (rst_i)
                 ce_i && clock_output_fuse_i ##1 pad_out_o[PIN_DCLK]);

endmodule : pdm_port_d_mux

// file: pdm_board_model.sv
// board side of port d: resolves each pad wire from every driver on it
// assumes pad outputs from pdm_port_d_mux and an optional bench drive
`timescale 1ns/1ns
module pdm_board_model (
    input  wire logic       clk_sys_i,
    input  wire logic [7:0] pad_out_i,
    input  wire logic [7:0] pad_oe_n_i,
    input  wire logic [7:0] pad_pullup_i,
    input  wire logic [7:0] ext_en_i,
    input  wire logic [7:0] ext_val_i,
    output logic      [7:0] wire_o
);
    logic [7:0] float_reg = 8'h55;
    // a released line without pull-up wanders instead of holding its last level
    always_ff @(posedge clk_sys_i) begin
        float_reg <= ~float_reg;
    end
    // the device pad wins over the weak board drive
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pad_oe_n_i[i]) wire_o[i] = pad_out_i[i];
            else if (ext_en_i[i]) wire_o[i] = ext_val_i[i];
            else if (pad_pullup_i[i]) wire_o[i] = 1'b1;
            else wire_o[i] = float_reg[i];
        end
    end
endmodule : pdm_board_model

// file: pdm_port_d_mux_bench.sv
// self-checking bench for pdm_port_d_mux with random and corner stimulus
// assumes pdm_board_model closes the pad loop back into pin_i
`timescale 1ns/1ns
module pdm_port_d_mux_bench;
    import pdm_pkg::*;
    logic        clk_sys_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        ce_i = 1'b1;
    logic [7:0]  port_out_i = 8'h00, port_dir_i = 8'h00, add_i = 8'h00;
    logic [7:0]  ext_en = 8'h00, ext_val = 8'h00, pin_w;
    logic        pu_off = 0, rx_on = 0, tx_on = 0, txd = 0, sync = 0, sclk = 0, spi_on = 0;
    logic        spi_mst = 0, sel = 0, sck = 0, mosi = 0, miso = 0, t0en = 0, t0 = 0;
    logic        t1en = 0, t1 = 0, s0en = 0, s0 = 0, fuse = 0, divclk = 0, irq_en = 0;
    logic [7:0]  pad_out, pad_oe_n, pad_pu, pin_val, n_oe, n_out, n_pu, n_ie;
    logic [7:0]  e_oe, e_out, e_pu, e_pv, m;
    logic [3:0]  e_spi;
    logic        irq, cap, st2, st0, sc_in, sck_in, mosi_in, miso_in, ss_n;
    logic [31:0] seed = 32'h30;
    int          n_mismatch = 0;
    int          n_compared = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    pdm_port_d_mux dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
        .port_out_i(port_out_i), .port_dir_i(port_dir_i), .pin_i(pin_w),
        .analog_digital_disable_i(add_i), .global_pullup_disable_i(pu_off),
        .receiver_enable_i(rx_on), .transmitter_enable_i(tx_on), .tx_data_i(txd),
        .serial_sync_mode_select_i(sync), .serial_transfer_clock_out_i(sclk),
        .spi_enable_bit_i(spi_on), .spi_master_select_i(spi_mst), .spi_pin_set_select_i(sel),
        .spi_sck_out_i(sck), .spi_mosi_out_i(mosi), .spi_miso_out_i(miso),
        .timer0_compare_out_enable_i(t0en), .timer0_compare_a_out_i(t0),
        .timer1_compare_out_enable_i(t1en), .timer1_compare_a_out_i(t1),
        .stage0_output0_enable_i(s0en), .stage0_output0_i(s0),
        .clock_output_fuse_i(fuse), .divided_clock_i(divclk),
        .ext_irq_zero_input_enable_i(irq_en), .pad_out_o(pad_out), .pad_oe_n_o(pad_oe_n),
        .pad_pullup_o(pad_pu), .pin_value_o(pin_val), .ext_irq_zero_o(irq),
        .timer1_capture_in_o(cap), .stage2_digital_in_o(st2), .stage0_digital_in_o(st0),
        .serial_transfer_clock_in_o(sc_in), .spi_sck_in_o(sck_in),
        .spi_mosi_in_o(mosi_in), .spi_miso_in_o(miso_in), .spi_slave_select_n_o(ss_n));
    pdm_board_model board (.clk_sys_i(clk_sys_i), .pad_out_i(pad_out), .pad_oe_n_i(pad_oe_n),
        .pad_pullup_i(pad_pu), .ext_en_i(ext_en), .ext_val_i(ext_val), .wire_o(pin_w));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic void model(output logic [7:0] oe, out, pu, ie);
        logic slv, mst;
        slv = spi_on & !spi_mst & sel;
        mst = spi_on & spi_mst & sel;
        oe = ~port_dir_i;
        out = port_out_i;
        // pull-up follows the direction register unless a function overrides it
        pu = ~port_dir_i & port_out_i & {8{!pu_off}};
        ie = ~add_i;
        ie[6] = irq_en | ~add_i[6];
        if (rx_on | slv) oe[4] = 1'b1;
        if (rx_on | slv) pu[4] = port_out_i[4] & !pu_off;
        if (mst) out[4] = sck;
        if (slv) oe[3] = 1'b1;
        if (slv) pu[3] = port_out_i[3] & !pu_off;
        if (tx_on) oe[3] = 1'b0;
        if (tx_on) pu[3] = 1'b0;
        out[3] = tx_on ? txd : t0en ? t0 : mst ? mosi : port_out_i[3];
        if (mst) oe[2] = 1'b1;
        if (mst) pu[2] = port_out_i[2] & !pu_off;
        out[2] = t1en ? t1 : slv ? miso : port_out_i[2];
        if (fuse) oe[1] = 1'b0;
        if (fuse) out[1] = divclk;
        if (slv) oe[0] = 1'b1;
        if (slv) pu[0] = port_out_i[0] & !pu_off;
        if (s0en) oe[0] = 1'b0;
        out[0] = s0en ? s0 : sync ? sclk : port_out_i[0];
    endfunction : model
    always_comb model(n_oe, n_out, n_pu, n_ie);
    // bit 1 keeps loading in reset so the divided clock can leave during reset
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            e_oe <= 8'hFD | (n_oe & 8'h02);
            e_out <= n_out & 8'h02;
            e_pu <= 8'h00;
            e_pv <= 8'h00;
            e_spi <= 4'h1;
        end else if (ce_i) begin
            e_oe <= n_oe;
            e_out <= n_out;
            e_pu <= n_pu;
            e_pv <= pin_w & n_ie;
            // spi inputs take one more stage behind the pin value
            e_spi <= {e_pv[4:2] & {3{sel}}, !(sel & !(e_pv[3] & e_pv[0]))};
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        n_compared++;
        if (seen !== want) begin
            n_mismatch++;
            $display("ERROR %0t pin group seen %h expected %h", $time, seen, want);
        end
    endtask : check
    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out
    task automatic drive(input int k);
        logic [31:0] r;
        r = rnd();
        port_out_i = r[7:0];
        port_dir_i = r[15:8];
        ext_en = r[23:16];
        ext_val = r[31:24];
        r = rnd();
        {pu_off, rx_on, tx_on, txd, sync, sclk, spi_on, spi_mst, sel, sck, mosi} = r[10:0];
        {miso, t0en, t0, t1en, t1, s0en, s0, fuse, divclk, irq_en} = r[20:11];
        ce_i = r[21] | r[22];
        add_i = r[30:23];
        case (k)
            0: {rx_on, spi_on, pu_off, port_dir_i[4], port_out_i[4]} = 5'h13;
            1: {tx_on, port_dir_i[3]} = 2'h2;
            2: {spi_on, spi_mst, sel, tx_on, s0en, port_dir_i} = {5'h14, 8'hFF};
            3: {spi_on, spi_mst, sel, port_dir_i[2], fuse, port_dir_i[1]} = 6'h3E;
            default: ;
        endcase
        if (k < 4) ce_i = 1'b1;
        port_dir_i[7] = 1'b0;
        port_out_i[7] = 1'b0;
        if (t0en) port_dir_i[3] = 1'b1;
        if (t1en) port_dir_i[2] = 1'b1;
    endtask : drive
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (40000) @(posedge clk_sys_i);
        n_mismatch++;
        close_out();
    end
    initial begin
        repeat (4) @(posedge clk_sys_i);
        for (int c = 0; c < 3000; c++) begin
            @(negedge clk_sys_i);
            m = rst_i ? 8'h02 : 8'h00;
            check(pad_oe_n | m, e_oe | m);
            check(pad_out & ~m, e_out & ~m);
            check(pad_pu, e_pu);
            check(pin_val, e_pv);
            check({3'h0, irq, cap, st2, st0, sc_in}, {3'h0, e_pv[6], e_pv[4], e_pv[2:0]});
            check({4'h0, sck_in, mosi_in, miso_in, ss_n}, {4'h0, e_spi});
            rst_i = (c >= 1500 && c < 1504);
            if (!rst_i) drive(c == 0 ? 0 : c == 1 ? 1 : c == 2 ? 2 : c == 3 ? 3 : 9);
            // after drive picks ce_i: pin 1 must keep loading through the reset
            if (c == 1499) ce_i = 1'b1;
        end
        close_out();
    end
endmodule : pdm_port_d_mux_bench
